// ### mpc_pkg.sv
// Purpose: constants and types for the mode parameter checker
// Assumes: registers reached over AHB-Lite, one aligned 32-bit word each
// Notes:   offsets below are byte addresses
// Functional notes
// - short descriptor: 4-byte count, reserved byte, 3-byte length, big-endian
// - long descriptor: 8-byte count, 4 reserved bytes, 4-byte length
// - count zero keeps capacity; all ones selects every available block; code takes 0FFFFFFFh short, 000FFFFFFFFFFFFFh long
// - count equal to or below capacity is accepted; below clips capacity
// - any other block count ends select with check condition
// - sense descriptor count holds exact user-addressable block count
// - lengths 4096, 4104, 4112, 4160, 4224 or zero accepted; others rejected
// - descriptor held pending for format only when block length changes
// - page starts with savable, subpage flags and code, then length, then data
// - sense savable flag one for saveable pages; select keeps it zero
// - subpage format flag zero short format, one long format
// - supported pages listed; pages 03 and 04 not savable
// - page length must match sensed length or check condition; code checks page 00 length (0Eh) only
// - unused page 00 fields reset to zero, except byte 12 (16h), and accepted unchecked
// - timer high nibble in byte 6 low bits, low part in byte 7
// - byte 5 holds format-degraded disable and aging enable; default 02h
// - merge flag one merges grown list into primary list on format
// - self-seek flag one and active gives random self-seeks
// - recovered non-data errors reported only with report flag set
// - format-degraded disable suppresses degraded sense for test unit ready
// - aging enabled: old queued commands run first come first served
// - overall command timer counts 50 ms units; zero disables; expiry aborts
// - aging limit sets maximum queue wait in 50 ms units
// - descriptor lengths 0, 8 and 16 accepted; code takes 8 with short format only, 16 with long format only
package mpc_pkg;
    localparam logic [7:0]  A_CMD     = 8'h00; // w: op, r: status
    localparam logic [7:0]  A_DESC0   = 8'h04; // descriptor bytes 0-3
    localparam logic [7:0]  A_DESC1   = 8'h08; // bytes 4-7
    localparam logic [7:0]  A_DESC2   = 8'h0C; // bytes 8-11
    localparam logic [7:0]  A_DESC3   = 8'h10; // bytes 12-15
    localparam logic [7:0]  A_PAGEHDR = 8'h14; // page bytes 0,1 in [15:0]
    localparam logic [7:0]  A_P0W0    = 8'h18; // page 00 bytes 2-5
    localparam logic [7:0]  A_P0W1    = 8'h1C; // bytes 6-9
    localparam logic [7:0]  A_P0W2    = 8'h20; // bytes 10-13
    localparam logic [7:0]  A_P0W3    = 8'h24; // bytes 14-15
    localparam logic [7:0]  A_CAPLO   = 8'h28; // current block count low
    localparam logic [7:0]  A_CAPHI   = 8'h2C;
    localparam logic [7:0]  A_BLEN    = 8'h30; // current block length
    localparam logic [7:0]  A_PENDLEN = 8'h34; // pending block length
    localparam logic [7:0]  A_FLAGS   = 8'h38; // page 00 flags out
    // command word fields
    localparam int CMD_GO     = 0;  // start check
    localparam int CMD_LONG   = 1;  // long descriptor format
    localparam int CMD_BDL_LO = 2;  // [3:2] descriptor length code
    localparam int CMD_FORMAT = 4;  // format unit done
    localparam int CMD_SENSE  = 5;  // build sense header for page
    localparam logic [1:0] BDL_NONE  = 2'h0; // 0 bytes
    localparam logic [1:0] BDL_SHORT = 2'h1; // 8 bytes
    localparam logic [1:0] BDL_LONG  = 2'h2; // 16 bytes
    localparam logic [7:0] DESC_LEN_SHORT = 8'h08;
    localparam logic [7:0] DESC_LEN_LONG  = 8'h10;
    localparam logic [31:0] LEN_4096 = 32'h0000_1000;
    localparam logic [31:0] LEN_4104 = 32'h0000_1008;
    localparam logic [31:0] LEN_4112 = 32'h0000_1010;
    localparam logic [31:0] LEN_4160 = 32'h0000_1040;
    localparam logic [31:0] LEN_4224 = 32'h0000_1080;
    localparam logic [63:0] ALL_SHORT = 64'h0000_0000_0FFF_FFFF;
    localparam logic [63:0] ALL_LONG  = 64'h000F_FFFF_FFFF_FFFF;
    localparam logic [7:0]  P0_LEN     = 8'h0E;
    localparam logic [7:0]  P0_B5_RST  = 8'h02; // aging enabled
    localparam logic [7:0]  P0_B11_RST = 8'h30;
    localparam logic [7:0]  P0_B12_RST = 8'h16;
    localparam int TICK_MS = 50;
    localparam int CLK_MHZ = 100;
    localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ; // 5,000,000
    // status result codes
    localparam logic [1:0] RES_NONE = 2'h0;
    localparam logic [1:0] RES_GOOD = 2'h1;
    localparam logic [1:0] RES_CHK  = 2'h2;
    typedef struct packed {
        logic        merge;       // defect_list_merge_flag
        logic        self_seek;   // random_self_seek_flag
        logic        rnd_report;  // recovered_nondata_report_flag
        logic        fdd;         // format_degraded_report_disable
        logic        aging_en;    // command_aging_enable
        logic [11:0] overall_command_timer;         // overall_command_timer
        logic [15:0] aging_limit;
    } mpc_flags_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CHECK = 3'b010,
        ST_DONE  = 3'b100
    } mpc_state_t;
endpackage : mpc_pkg

// ### mpc_top.sv
// Purpose: mode select checker and mode sense helper behind AHB-Lite
// Assumes: software loads descriptor and page words, then writes the command
// Notes:   one check takes one cycle; result shown in the status word
`timescale 1ns/1ps
module mpc_top #(
    parameter logic [63:0] CAP_DEFAULT = 64'h0000_0000_0100_0000,
    parameter int          TICK_CYCLES = mpc_pkg::TICK_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        recovered_nondata_err,
    input  wire logic        per_enabled,
    input  wire logic        tur_degraded,
    input  wire logic        spinning,
    input  wire logic        start_unit,
    input  wire logic        cmd_active,
    output mpc_pkg::mpc_flags_t flags_out,
    output logic             report_nondata,
    output logic             report_degraded_tur,
    output logic             self_seek_active,
    output logic             merge_on_format,
    output logic             tick_50ms,
    output logic             cmd_timeout
);
    import mpc_pkg::*;

    // bus address phase capture
    logic [7:0]  a_reg, a_next;
    logic        wr_reg, wr_next;
    logic        rd_reg, rd_next;
    // software loaded state
    logic [31:0] cmd_reg, cmd_next;
    logic [31:0] d0_reg, d0_next, d1_reg, d1_next, d2_reg, d2_next, d3_reg, d3_next;
    logic [15:0] ph_reg, ph_next;
    logic [7:0]  p0_reg [2:15];
    logic [7:0]  p0_next [2:15];
    // device state
    logic [63:0] cap_reg, cap_next;
    logic [31:0] blen_reg, blen_next, plen_reg, plen_next;
    logic        pend_reg, pend_next;
    logic [1:0]  res_reg, res_next;
    logic [7:0]  sense_hdr_reg, sense_hdr_next;
    mpc_state_t  st_reg, st_next;
    logic        seek_arm_reg, seek_arm_next;
    logic [31:0] rdata_next;

    // descriptor decode, big-endian
    logic [63:0] cnt;
    logic [31:0] len;
    logic [1:0]  bdl;
    logic        long_fmt, cnt_ok, len_ok, bdl_ok, page_ok;
    always_comb begin
        long_fmt = cmd_reg[CMD_LONG];
        bdl      = cmd_reg[CMD_BDL_LO +: 2];
        if (long_fmt) begin
            cnt = {d0_reg, d1_reg};
            len = d3_reg;
        end else begin
            cnt = {32'h0000_0000, d0_reg};
            len = {8'h00, d1_reg[23:0]};
        end
        bdl_ok = (bdl == BDL_NONE) || (bdl == BDL_SHORT && !long_fmt)
               || (bdl == BDL_LONG && long_fmt);
        cnt_ok = (cnt == 64'h0) || (cnt == (long_fmt ? ALL_LONG : ALL_SHORT))
               || (cnt <= cap_reg);
        len_ok = (len == LEN_4096) || (len == LEN_4104) || (len == LEN_4112)
               || (len == LEN_4160) || (len == LEN_4224) || (len == 32'h0);
        // page 00 header: savable reserved, length must match
        page_ok = !ph_reg[7] && (ph_reg[5:0] != 6'h00 || ph_reg[15:8] == P0_LEN);
    end

    // sense header byte for a supported page
    function automatic logic [7:0] sense_byte0(input logic [5:0] pc);
        logic ps;
        ps = !(pc == 6'h03 || pc == 6'h04);
        sense_byte0 = {ps, 1'b0, pc};
    endfunction : sense_byte0

    // next state of bus, checker and loaded words
    always_comb begin
        a_next = a_reg;
        wr_next = 1'b0;
        rd_next = 1'b0;
        cmd_next = cmd_reg;
        d0_next = d0_reg;
        d1_next = d1_reg;
        d2_next = d2_reg;
        d3_next = d3_reg;
        ph_next = ph_reg;
        for (int i = 2; i < 16; i++) begin
            p0_next[i] = p0_reg[i];
        end
        cap_next = cap_reg;
        blen_next = blen_reg;
        plen_next = plen_reg;
        pend_next = pend_reg;
        res_next = res_reg;
        sense_hdr_next = sense_hdr_reg;
        st_next = st_reg;
        rdata_next = 32'h0000_0000;
        if (hsel && hready && htrans[1]) begin
            a_next = haddr;
            wr_next = hwrite;
            rd_next = !hwrite;
        end
        if (wr_reg) begin
            case (a_reg)
                A_CMD: begin
                    cmd_next = hwdata;
                    if (hwdata[CMD_GO]) begin
                        st_next = ST_CHECK;
                        res_next = RES_NONE;
                    end
                    if (hwdata[CMD_SENSE]) begin
                        sense_hdr_next = sense_byte0(hwdata[13:8]);
                    end
                    if (hwdata[CMD_FORMAT] && pend_reg) begin
                        blen_next = plen_reg;
                        pend_next = 1'b0;
                    end
                end
                A_DESC0: d0_next = hwdata;
                A_DESC1: d1_next = hwdata;
                A_DESC2: d2_next = hwdata;
                A_DESC3: d3_next = hwdata;
                A_PAGEHDR: ph_next = hwdata[15:0];
                // unused fields taken as written, unchecked
                A_P0W0: {p0_next[2], p0_next[3], p0_next[4], p0_next[5]} = hwdata;
                A_P0W1: {p0_next[6], p0_next[7], p0_next[8], p0_next[9]} = hwdata;
                A_P0W2: {p0_next[10], p0_next[11], p0_next[12], p0_next[13]} = hwdata;
                A_P0W3: {p0_next[14], p0_next[15]} = hwdata[31:16];
                default: ;
            endcase
        end
        if (rd_reg) begin
            case (a_reg)
                A_CMD:     rdata_next = {sense_hdr_reg, 16'h0000, 5'h00, pend_reg, res_reg};
                A_DESC0:   rdata_next = d0_reg;
                A_DESC1:   rdata_next = d1_reg;
                A_DESC2:   rdata_next = d2_reg;
                A_DESC3:   rdata_next = d3_reg;
                A_PAGEHDR: rdata_next = {16'h0000, ph_reg};
                A_CAPLO:   rdata_next = cap_reg[31:0];
                A_CAPHI:   rdata_next = cap_reg[63:32];
                A_BLEN:    rdata_next = blen_reg;
                A_PENDLEN: rdata_next = plen_reg;
                A_FLAGS:   rdata_next = {15'h0, flags_out[32:16]};
                default:   rdata_next = 32'h0000_0000;
            endcase
        end
        // check sequence
        case (st_reg)
            ST_IDLE: ;
            ST_CHECK: begin
                if (!bdl_ok || !page_ok || (bdl != BDL_NONE && (!cnt_ok || !len_ok))) begin
                    res_next = RES_CHK;
                end else begin
                    res_next = RES_GOOD;
                    if (bdl != BDL_NONE) begin
                        if (cnt != 64'h0 && cnt != (long_fmt ? ALL_LONG : ALL_SHORT)) begin
                            cap_next = cnt;
                        end else if (cnt != 64'h0) begin
                            cap_next = CAP_DEFAULT;
                        end
                        if (len != 32'h0 && len != blen_reg) begin
                            plen_next = len;
                            pend_next = 1'b1;
                        end
                    end
                end
                st_next = ST_DONE;
            end
            ST_DONE: st_next = ST_IDLE;
            default: st_next = ST_IDLE;
        endcase
    end

    // registers of bus and checker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_reg <= 8'h00;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            cmd_reg <= 32'h0000_0000;
            d0_reg <= 32'h0000_0000;
            d1_reg <= 32'h0000_0000;
            d2_reg <= 32'h0000_0000;
            d3_reg <= 32'h0000_0000;
            ph_reg <= 16'h0000;
            for (int i = 2; i < 16; i++) begin
                p0_reg[i] <= 8'h00;
            end
            p0_reg[5] <= P0_B5_RST;
            p0_reg[11] <= P0_B11_RST;
            p0_reg[12] <= P0_B12_RST;
            cap_reg <= CAP_DEFAULT;
            blen_reg <= LEN_4096;
            plen_reg <= LEN_4096;
            pend_reg <= 1'b0;
            res_reg <= RES_NONE;
            sense_hdr_reg <= 8'h00;
            st_reg <= ST_IDLE;
            hrdata <= 32'h0000_0000;
        end else begin
            a_reg <= a_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cmd_reg <= cmd_next;
            d0_reg <= d0_next;
            d1_reg <= d1_next;
            d2_reg <= d2_next;
            d3_reg <= d3_next;
            ph_reg <= ph_next;
            for (int i = 2; i < 16; i++) begin
                p0_reg[i] <= p0_next[i];
            end
            cap_reg <= cap_next;
            blen_reg <= blen_next;
            plen_reg <= plen_next;
            pend_reg <= pend_next;
            res_reg <= res_next;
            sense_hdr_reg <= sense_hdr_next;
            st_reg <= st_next;
            hrdata <= rdata_next;
        end
    end

    // pin inputs synchronised, two flops each
    logic [5:0] sy1_reg, sy2_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sy1_reg <= 6'h00;
            sy2_reg <= 6'h00;
        end else begin
            sy1_reg <= {recovered_nondata_err, per_enabled, tur_degraded,
                        spinning, start_unit, cmd_active};
            sy2_reg <= sy1_reg;
        end
    end

    // page 00 flags and their effects
    mpc_flags_t fl;
    logic [22:0] tick_cnt_reg, tick_cnt_next;
    logic [11:0] oct_cnt_reg, oct_cnt_next;
    logic        start_d_reg;
    logic        tick;
    always_comb begin
        fl.merge       = p0_reg[2][4];
        fl.self_seek   = p0_reg[3][6];
        fl.rnd_report  = p0_reg[3][1];
        fl.fdd         = p0_reg[5][4];
        fl.aging_en    = p0_reg[5][1];
        fl.overall_command_timer         = {p0_reg[6][3:0], p0_reg[7]};
        fl.aging_limit = {p0_reg[10], p0_reg[11]};
        tick = (tick_cnt_reg == 23'(TICK_CYCLES - 1));
        tick_cnt_next = tick ? 23'h000000 : tick_cnt_reg + 23'h000001;
        seek_arm_next = seek_arm_reg;
        if (!fl.self_seek) begin
            seek_arm_next = 1'b0;
        end else if (sy2_reg[1] && !start_d_reg && !sy2_reg[2]) begin
            seek_arm_next = 1'b1;
        end
        oct_cnt_next = oct_cnt_reg;
        if (!sy2_reg[0]) begin
            oct_cnt_next = 12'h000;
        end else if (tick && oct_cnt_reg != 12'hFFF) begin
            oct_cnt_next = oct_cnt_reg + 12'h001;
        end
    end

    // flag effect registers and outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_reg <= 23'h000000;
            oct_cnt_reg <= 12'h000;
            seek_arm_reg <= 1'b0;
            start_d_reg <= 1'b0;
            flags_out <= '0;
            report_nondata <= 1'b0;
            report_degraded_tur <= 1'b0;
            self_seek_active <= 1'b0;
            merge_on_format <= 1'b0;
            tick_50ms <= 1'b0;
            cmd_timeout <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            oct_cnt_reg <= oct_cnt_next;
            seek_arm_reg <= seek_arm_next;
            start_d_reg <= sy2_reg[1];
            flags_out <= fl;
            report_nondata <= sy2_reg[5] && sy2_reg[4] && fl.rnd_report;
            report_degraded_tur <= sy2_reg[3] && !fl.fdd;
            self_seek_active <= seek_arm_reg && fl.self_seek;
            merge_on_format <= fl.merge;
            tick_50ms <= tick;
            cmd_timeout <= sy2_reg[0] && fl.overall_command_timer != 12'h000 && oct_cnt_reg >= fl.overall_command_timer;
            // one wait state on reads so registered read data stands at the data phase end
            hreadyout <= !(hsel && hready && htrans[1] && !hwrite);
            hresp <= 1'b0;
        end
    end

    // checks on the checker
    AST_CHECK_ONE_CYCLE: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == ST_CHECK |=> st_reg == ST_DONE && res_reg != RES_NONE)
        else $error("check did not finish in one cycle");
    AST_BAD_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == ST_CHECK && bdl != BDL_NONE && !len_ok |=> res_reg == RES_CHK)
        else $error("bad block length accepted");
    AST_CLIP: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == ST_CHECK && res_next == RES_GOOD && bdl != BDL_NONE && cnt != 64'h0
        && cnt < cap_reg |=> cap_reg == $past(cnt))
        else $error("capacity not clipped");
    AST_ZERO_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == ST_CHECK && cnt == 64'h0 |=> $stable(cap_reg))
        else $error("zero count changed capacity");
    AST_PENDING: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == ST_CHECK && res_next == RES_GOOD && bdl != BDL_NONE
        && len == blen_reg |=> $stable(pend_reg))
        else $error("pending set for same length");
    AST_PAGE_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == ST_CHECK && ph_reg[5:0] == 6'h00 && ph_reg[15:8] != P0_LEN
        |=> res_reg == RES_CHK)
        else $error("page length mismatch accepted");
    AST_TUR_FDD: assert property (@(posedge hclk) disable iff (!hresetn)
        fl.fdd |=> !report_degraded_tur)
        else $error("degraded reported with disable set");
    AST_SEEK_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        !fl.self_seek ##1 !fl.self_seek |=> !self_seek_active)
        else $error("self-seek active with flag clear");
    AST_NONDATA: assert property (@(posedge hclk) disable iff (!hresetn)
        !fl.rnd_report |=> !report_nondata)
        else $error("nondata reported with flag clear");
    // read data phase: one low cycle, then ready with the data
    AST_RD_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_reg |-> !hreadyout ##1 hreadyout)
        else $error("read wait state missing");
    COV_GOOD: cover property (@(posedge hclk) st_reg == ST_CHECK ##1 res_reg == RES_GOOD);
    COV_CHK: cover property (@(posedge hclk) st_reg == ST_CHECK ##1 res_reg == RES_CHK);
    COV_PEND: cover property (@(posedge hclk) $rose(pend_reg));
endmodule : mpc_top

// ### mpc_drive_model.sv
// Purpose: drive-side partner giving spin state and start unit level
// Assumes: stop_start is a one-cycle request from the bench
// Notes:   stops the spindle, then raises start unit while still stopped
`timescale 1ns/1ps
module mpc_drive_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic stop_start,
    output logic      spinning,
    output logic      start_unit
);
    logic [3:0] seq_reg;
    // stop unit then start unit sequence, saturating at the end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_reg <= 4'h0;
        end else if (stop_start) begin
            seq_reg <= 4'h1;
        end else if (seq_reg != 4'h0 && seq_reg != 4'hF) begin
            seq_reg <= seq_reg + 4'h1;
        end
    end
    // spindle off for steps 1 to B, start unit rises at step 8
    assign spinning   = (seq_reg == 4'h0) || (seq_reg >= 4'hC);
    assign start_unit = (seq_reg >= 4'h8);
endmodule : mpc_drive_model

// ### mode_parameter_checker_tb_top.sv
// Purpose: self-checking bench for the mode parameter checker
// Assumes: AHB-Lite slave with a read wait state, result readable 4 cycles after go
// Notes:   short tick and small capacity keep the run brief
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s exp %h got %h", nm, e, g); end end
module mode_parameter_checker_tb_top;
    import mpc_pkg::*;
    localparam logic [63:0] CAP = 64'h0000_0000_0000_1000;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, stop_start = 1'b0;
    logic cmd_active = 1'b0, spinning, start_unit, hreadyout, hresp;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, q, scr;
    logic [31:0] lens [6] = '{LEN_4096, LEN_4104, LEN_4112, LEN_4160, LEN_4224, 32'h0};
    logic [5:0] pg [5] = '{6'h00, 6'h03, 6'h04, 6'h08, 6'h1C};
    mpc_flags_t flags_out;
    logic nd, dg, ss, mg, tk, cto, nde = 1'b0;
    int error_cnt = 0, n_checks = 0, k, tks = 0;
    always #5 hclk = ~hclk;
    mpc_drive_model i_drive (.hclk(hclk), .hresetn(hresetn), .stop_start(stop_start),
        .spinning(spinning), .start_unit(start_unit));
    mpc_top #(.CAP_DEFAULT(CAP), .TICK_CYCLES(20)) i_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .recovered_nondata_err(nde), .per_enabled(1'b1),
        .tur_degraded(1'b1), .spinning(spinning), .start_unit(start_unit),
        .cmd_active(cmd_active), .flags_out(flags_out), .report_nondata(nd),
        .report_degraded_tur(dg), .self_seek_active(ss), .merge_on_format(mg),
        .tick_50ms(tk), .cmd_timeout(cto));
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic wait_rdy;
        int i;
        i = 0;
        do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 50);
        if (i >= 50) begin error_cnt++; give_verdict(); end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
        wait_rdy();
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        wait_rdy();
        q = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic sel(input logic [31:0] c, w0, w1, w2, w3, input logic [1:0] e);
        wr(A_DESC0, w0); wr(A_DESC1, w1); wr(A_DESC2, w2); wr(A_DESC3, w3); wr(A_CMD, c);
        repeat (4) @(posedge hclk);
        xfer(1'b0, A_CMD, 32'h0);
        `CHK("result", e, q[1:0])
    endtask : sel
    // main sequence
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (5) @(posedge hclk);
        `CHK("aging_en", 1'b1, flags_out.aging_en)
        `CHK("aging_limit", 16'h0030, flags_out.aging_limit)
        `CHK("degraded", 1'b1, dg)
        `CHK("nondata", 1'b0, nd)
        wr(A_PAGEHDR, 32'h0000_0E00);
        foreach (lens[i]) sel(32'h5, 32'h0, lens[i], 32'h0, 32'h0, RES_GOOD);
        sel(32'h5, 32'h0, 32'h0000_1004, 32'h0, 32'h0, RES_CHK);
        sel(32'h5, CAP[31:0] + 32'h1, LEN_4096, 32'h0, 32'h0, RES_CHK);
        sel(32'h5, CAP[31:0] - 32'h1, LEN_4096, 32'h0, 32'h0, RES_GOOD);
        xfer(1'b0, A_CAPLO, 32'h0);
        `CHK("caplo", CAP[31:0] - 32'h1, q)
        sel(32'h5, ALL_SHORT[31:0], LEN_4096, 32'h0, 32'h0, RES_GOOD);
        xfer(1'b0, A_CAPLO, 32'h0);
        `CHK("caplo", CAP[31:0], q)
        sel(32'hB, ALL_LONG[63:32], ALL_LONG[31:0], 32'h0, LEN_4096, RES_GOOD);
        sel(32'hB, 32'h0, CAP[31:0] + 32'h1, 32'h0, LEN_4096, RES_CHK);
        sel(32'hF, 32'h0, 32'h0, 32'h0, LEN_4096, RES_CHK);
        wr(A_CMD, 32'h10);
        xfer(1'b0, A_BLEN, 32'h0);
        `CHK("blen", LEN_4224, q)
        sel(32'h5, 32'h0, LEN_4104, 32'h0, 32'h0, RES_GOOD);
        `CHK("pending", 1'b1, q[2])
        wr(A_CMD, 32'h10);
        repeat (4) @(posedge hclk);
        xfer(1'b0, A_BLEN, 32'h0);
        `CHK("blen", LEN_4104, q)
        sel(32'h5, 32'h0, LEN_4104, 32'h0, 32'h0, RES_GOOD);
        `CHK("pending", 1'b0, q[2])
        wr(A_PAGEHDR, 32'h0000_0E80);
        sel(32'h1, 32'h0, 32'h0, 32'h0, 32'h0, RES_CHK);
        wr(A_PAGEHDR, 32'h0000_0D00);
        sel(32'h1, 32'h0, 32'h0, 32'h0, 32'h0, RES_CHK);
        wr(A_PAGEHDR, 32'h0000_0E00);
        foreach (pg[i]) begin
            wr(A_CMD, {18'h0, pg[i], 8'h20});
            repeat (4) @(posedge hclk);
            xfer(1'b0, A_CMD, 32'h0);
            `CHK("sense", {pg[i] != 6'h03 && pg[i] != 6'h04, 1'b0, pg[i]}, q[31:24])
        end
        wr(A_P0W0, 32'h1042_0002);
        wr(A_P0W1, 32'h4102_0000);
        wr(A_P0W2, 32'h0012_3400);
        sel(32'h1, 32'h0, 32'h0, 32'h0, 32'h0, RES_GOOD);
        `CHK("oct", 12'h102, flags_out.overall_command_timer)
        `CHK("aging_limit", 16'h0012, flags_out.aging_limit)
        `CHK("self_seek", 1'b1, flags_out.self_seek)
        `CHK("merge", 1'b1, mg)
        `CHK("nondata", 1'b0, nd)
        nde <= 1'b1;
        wr(A_P0W0, 32'h1042_0012);
        repeat (4) @(posedge hclk);
        `CHK("nondata", 1'b1, nd)
        `CHK("degraded", 1'b0, dg)
        stop_start <= 1'b1;
        @(posedge hclk);
        stop_start <= 1'b0;
        for (k = 0; k < 50 && ss !== 1'b1; k++) @(posedge hclk);
        `CHK("self_seek_active", 1'b1, ss)
        cmd_active <= 1'b1;
        repeat (5000) @(posedge hclk);
        `CHK("timeout_early", 1'b0, cto)
        for (k = 0; k < 400 && cto !== 1'b1; k++) @(posedge hclk);
        `CHK("timeout", 1'b1, cto)
        repeat (200) begin @(posedge hclk); tks += tk; end
        `CHK("ticks", 10, tks)
        give_verdict();
    end
endmodule : mode_parameter_checker_tb_top
